// File: spm_aps_fail.sv
// shared constants for the overhead monitor, and the protection byte failure detector
// assumes one k1/k2 pair per frame from the first sts-1, on the clk_sys domain
`timescale 1ns/1ps
`default_nettype none

package spm_pkg;
  localparam int unsigned STS_NUM    = 12;
  localparam int unsigned TOH_NUM    = 21;
  localparam logic [3:0]  STS_FIRST  = 4'h0;
  // overhead byte selectors
  localparam logic [4:0]  SEL_D1     = 5'h00;
  localparam logic [4:0]  SEL_E1     = 5'h0C;
  localparam logic [4:0]  SEL_E2     = 5'h0D;
  localparam logic [4:0]  SEL_F1     = 5'h0E;
  localparam logic [4:0]  SEL_H1     = 5'h0F;
  localparam logic [4:0]  SEL_H2     = 5'h10;
  localparam logic [4:0]  SEL_K1     = 5'h11;
  localparam logic [4:0]  SEL_K2     = 5'h12;
  localparam logic [4:0]  SEL_Z1     = 5'h13;
  localparam logic [4:0]  SEL_Z2     = 5'h14;
  localparam logic [4:0]  SEL_LAST   = 5'h14;
  // concatenation indication
  localparam logic [7:0]  CONCAT_H1  = 8'h93;
  localparam logic [7:0]  CONCAT_H2  = 8'hFF;
  // channel numbers
  localparam logic [3:0]  CHAN_NULL  = 4'h0;
  localparam logic [3:0]  CHAN_EXTRA = 4'hF;
  // switching mode codes
  localparam logic [2:0]  MODE_UNI   = 3'h4;
  localparam logic [2:0]  MODE_BI    = 3'h5;
  localparam logic [2:0]  MODE_RFI   = 3'h6;
  localparam logic [2:0]  MODE_AIS   = 3'h7;
  // byte failure detection
  localparam logic [3:0]  ABF_WINDOW = 4'h8;
  localparam logic [1:0]  ABF_RUN    = 2'h3;
  localparam logic [15:0] CNT_ONE    = 16'h0001;

  typedef enum logic [3:0] {
    SPM_NO_REQUEST    = 4'h0,
    SPM_DO_NOT_REVERT = 4'h1,
    SPM_REVERSE_REQ   = 4'h2,
    SPM_EXERCISE      = 4'h4,
    SPM_WAIT_RESTORE  = 4'h6,
    SPM_MANUAL        = 4'h8,
    SPM_DEGRADE_LOW   = 4'hA,
    SPM_DEGRADE_HIGH  = 4'hB,
    SPM_FAIL_LOW      = 4'hC,
    SPM_FAIL_HIGH     = 4'hD,
    SPM_FORCED        = 4'hE,
    SPM_LOCKOUT       = 4'hF
  } spm_state_e;
endpackage

module spm_aps_fail (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clear,
  input  wire logic        upd,
  input  wire logic [15:0] k12,
  output logic             fail_q
);
  import spm_pkg::*;

  logic [15:0] last_q, last_d;
  logic        have_q, have_d;
  logic [1:0]  run_q, run_d;
  logic [3:0]  win_q, win_d;
  logic        fail_d;

  always_comb begin
    last_d = last_q;
    have_d = have_q;
    run_d  = run_q;
    win_d  = win_q;
    fail_d = 1'b0;
    if (clear) begin
      have_d = 1'b0;
      run_d  = 2'h0;
      win_d  = 4'h0;
    end else if (upd) begin
      last_d = k12;
      have_d = 1'b1;
      // run length of identical pairs, saturating at the needed length
      if (have_q && k12 == last_q) begin
        run_d = (run_q == ABF_RUN) ? ABF_RUN : run_q + 2'h1;
      end else begin
        run_d = 2'h1;
      end
      if (run_d == ABF_RUN) begin
        win_d = 4'h0;
      end else if (win_q + 4'h1 == ABF_WINDOW) begin
        fail_d = 1'b1;
        win_d  = 4'h0;
      end else begin
        win_d = win_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_q <= 16'h0000;
      have_q <= 1'b0;
      run_q  <= 2'h0;
      win_q  <= 4'h0;
      fail_q <= 1'b0;
    end else begin
      last_q <= last_d;
      have_q <= have_d;
      run_q  <= run_d;
      win_q  <= win_d;
      fail_q <= fail_d;
    end
  end

  abf_window_a: assert property (@(posedge clk_sys) disable iff (reset)
    fail_q |-> $past(upd) && $past(win_q) == 4'h7 && $past(run_d) != ABF_RUN)
    else $error("byte failure without eight unstable frames");

  abf_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
    upd && !clear && have_q && k12 == last_q && run_q == 2'h2 |=> !fail_q && win_q == 4'h0)
    else $error("byte failure despite three identical frames");
endmodule

`default_nettype wire

// File: spm_overhead_monitor.sv
// transport overhead monitor: pointer capture, concatenation check, k1/k2 decode,
// protection state change and byte failure seconds
// assumes overhead bytes arrive one per cycle on clk_sys from a same-domain deframer
//
// Summary of operation
// - hold the pointer byte pair of each of the twelve sts-1s separately
// - concatenation valid only when sts-1s 2 to 12 carry 93 then FF
// - count each second in which the protection message changed
// - count each second in which a protection byte failure was declared
// - failure when eight frames pass without three identical consecutive k1/k2
// - requested channel comes from k1 bits 5 to 8
// - channel 0 null, 15 extra traffic, 1 to 14 working
// - bridged channel comes from k2 bits 1 to 4
// - k1 bits 1 to 4 give state codes 0 to 7, three unused
// - k1 state codes 8 to 15 decoded, code 9 unused
// - k2 bits 6 to 8 give switching mode, codes 0 to 3 reserved
// - hold latest value of every transport overhead byte of the first sts-1 only
`timescale 1ns/1ps
`default_nettype none

module spm_overhead_monitor (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       oh_valid,
  input  wire logic [3:0]                 oh_sts,
  input  wire logic [4:0]                 oh_sel,
  input  wire logic [7:0]                 oh_data,
  input  wire logic                       sec_tick,
  input  wire logic                       test_start,
  output logic      [11:0][7:0]           ptr_h1_q,
  output logic      [11:0][7:0]           ptr_h2_q,
  output logic                            concat_ok_q,
  output logic      [20:0][7:0]           toh_q,
  output logic      [3:0]                 req_chan_q,
  output logic                            chan_null_q,
  output logic                            chan_extra_q,
  output logic                            chan_working_q,
  output logic      [3:0]                 bridge_chan_q,
  output spm_pkg::spm_state_e             protection_state_message_q,
  output logic                            state_unused_q,
  output logic                            arch_one_to_n_q,
  output logic      [2:0]                 switch_mode_q,
  output logic                            mode_reserved_q,
  output logic                            mode_unidir_q,
  output logic                            mode_bidir_q,
  output logic                            remote_failure_indication_q,
  output logic                            line_ais_q,
  output logic                            aps_fail_q,
  output logic      [15:0]                state_chg_secs_q,
  output logic      [15:0]                byte_fail_secs_q
);
  import spm_pkg::*;

  logic [11:0][7:0] ptr_h1_d, ptr_h2_d;
  logic [20:0][7:0] toh_d;
  logic [11:0]      ptr_match;
  logic             concat_ok_d;
  logic             aps_upd, aps_chg, abf_fail;
  logic [15:0]      k12_new, prev_k12_q, prev_k12_d;
  logic             have_prev_q, have_prev_d;
  logic [3:0]       req_chan_d, bridge_chan_d;
  logic             chan_null_d, chan_extra_d, chan_working_d;
  spm_state_e       psm_d;
  logic             state_unused_d, arch_d;
  logic [2:0]       mode_d;
  logic             mode_res_d, mode_uni_d, mode_bi_d, rfi_d, ais_d;
  logic             aps_fail_d;
  logic             scs_seen_q, scs_seen_d, abf_seen_q, abf_seen_d;
  logic [15:0]      scs_cnt_d, abf_cnt_d;

  // capture of overhead bytes
  genvar g;
  generate
    for (g = 0; g < STS_NUM; g++) begin : g_match
      assign ptr_match[g] = (ptr_h1_q[g] == CONCAT_H1) && (ptr_h2_q[g] == CONCAT_H2);
    end
  endgenerate

  always_comb begin
    toh_d       = toh_q;
    ptr_h1_d    = ptr_h1_q;
    ptr_h2_d    = ptr_h2_q;
    if (oh_valid && oh_sel <= SEL_LAST) begin
      if (oh_sts == STS_FIRST) begin
        toh_d[oh_sel] = oh_data;
      end
      if (oh_sts < 4'(STS_NUM) && oh_sel == SEL_H1) begin
        ptr_h1_d[oh_sts] = oh_data;
      end
      if (oh_sts < 4'(STS_NUM) && oh_sel == SEL_H2) begin
        ptr_h2_d[oh_sts] = oh_data;
      end
    end
    // sts-1 number one carries the real pointer, so it is left out
    concat_ok_d = &ptr_match[11:1];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      toh_q       <= '0;
      ptr_h1_q    <= '0;
      ptr_h2_q    <= '0;
      concat_ok_q <= 1'b0;
    end else begin
      toh_q       <= toh_d;
      ptr_h1_q    <= ptr_h1_d;
      ptr_h2_q    <= ptr_h2_d;
      concat_ok_q <= concat_ok_d;
    end
  end

  // k2 closes the pair; k1 of the same frame is already held
  assign aps_upd = oh_valid && oh_sts == STS_FIRST && oh_sel == SEL_K2;
  assign k12_new = {toh_q[SEL_K1], oh_data};
  // toh_q already holds this frame's k1, so the previous pair is kept apart
  assign aps_chg = aps_upd && have_prev_q && k12_new != prev_k12_q;

  // decode of protection bytes
  always_comb begin
    have_prev_d    = have_prev_q;
    prev_k12_d     = prev_k12_q;
    req_chan_d     = req_chan_q;
    chan_null_d    = chan_null_q;
    chan_extra_d   = chan_extra_q;
    chan_working_d = chan_working_q;
    bridge_chan_d  = bridge_chan_q;
    psm_d          = protection_state_message_q;
    state_unused_d = state_unused_q;
    arch_d         = arch_one_to_n_q;
    mode_d         = switch_mode_q;
    mode_res_d     = mode_reserved_q;
    mode_uni_d     = mode_unidir_q;
    mode_bi_d      = mode_bidir_q;
    rfi_d          = remote_failure_indication_q;
    ais_d          = line_ais_q;
    if (test_start) begin
      have_prev_d = 1'b0;
    end else if (aps_upd) begin
      have_prev_d    = 1'b1;
      prev_k12_d     = k12_new;
      req_chan_d     = k12_new[11:8];
      chan_null_d    = k12_new[11:8] == CHAN_NULL;
      chan_extra_d   = k12_new[11:8] == CHAN_EXTRA;
      chan_working_d = k12_new[11:8] != CHAN_NULL && k12_new[11:8] != CHAN_EXTRA;
      bridge_chan_d  = k12_new[7:4];
      psm_d          = spm_state_e'(k12_new[15:12]);
      case (k12_new[15:12])
        4'h3, 4'h5, 4'h7: state_unused_d = 1'b1;
        4'h9:             state_unused_d = 1'b1;
        default:          state_unused_d = 1'b0;
      endcase
      arch_d         = k12_new[3];
      mode_d         = k12_new[2:0];
      mode_res_d     = ~k12_new[2];
      mode_uni_d     = k12_new[2:0] == MODE_UNI;
      mode_bi_d      = k12_new[2:0] == MODE_BI;
      rfi_d          = k12_new[2:0] == MODE_RFI;
      ais_d          = k12_new[2:0] == MODE_AIS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      have_prev_q                 <= 1'b0;
      prev_k12_q                  <= 16'h0000;
      req_chan_q                  <= 4'h0;
      chan_null_q                 <= 1'b1;
      chan_extra_q                <= 1'b0;
      chan_working_q              <= 1'b0;
      bridge_chan_q               <= 4'h0;
      protection_state_message_q  <= SPM_NO_REQUEST;
      state_unused_q              <= 1'b0;
      arch_one_to_n_q             <= 1'b0;
      switch_mode_q               <= 3'h0;
      mode_reserved_q             <= 1'b1;
      mode_unidir_q               <= 1'b0;
      mode_bidir_q                <= 1'b0;
      remote_failure_indication_q <= 1'b0;
      line_ais_q                  <= 1'b0;
    end else begin
      have_prev_q                 <= have_prev_d;
      prev_k12_q                  <= prev_k12_d;
      req_chan_q                  <= req_chan_d;
      chan_null_q                 <= chan_null_d;
      chan_extra_q                <= chan_extra_d;
      chan_working_q              <= chan_working_d;
      bridge_chan_q               <= bridge_chan_d;
      protection_state_message_q  <= psm_d;
      state_unused_q              <= state_unused_d;
      arch_one_to_n_q             <= arch_d;
      switch_mode_q               <= mode_d;
      mode_reserved_q             <= mode_res_d;
      mode_unidir_q               <= mode_uni_d;
      mode_bidir_q                <= mode_bi_d;
      remote_failure_indication_q <= rfi_d;
      line_ais_q                  <= ais_d;
    end
  end

  spm_aps_fail u_aps_fail (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clear   (test_start),
    .upd     (aps_upd),
    .k12     (k12_new),
    .fail_q  (abf_fail)
  );

  // per-second counters; an event on the tick cycle still counts in the closing second
  always_comb begin
    aps_fail_d = abf_fail;
    scs_seen_d = scs_seen_q | aps_chg;
    abf_seen_d = abf_seen_q | abf_fail;
    scs_cnt_d  = state_chg_secs_q;
    abf_cnt_d  = byte_fail_secs_q;
    if (sec_tick) begin
      if (scs_seen_q | aps_chg) begin
        scs_cnt_d = state_chg_secs_q + CNT_ONE;
      end
      if (abf_seen_q | abf_fail) begin
        abf_cnt_d = byte_fail_secs_q + CNT_ONE;
      end
      scs_seen_d = 1'b0;
      abf_seen_d = 1'b0;
    end
    if (test_start) begin
      scs_seen_d = 1'b0;
      abf_seen_d = 1'b0;
      scs_cnt_d  = 16'h0000;
      abf_cnt_d  = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aps_fail_q       <= 1'b0;
      scs_seen_q       <= 1'b0;
      abf_seen_q       <= 1'b0;
      state_chg_secs_q <= 16'h0000;
      byte_fail_secs_q <= 16'h0000;
    end else begin
      aps_fail_q       <= aps_fail_d;
      scs_seen_q       <= scs_seen_d;
      abf_seen_q       <= abf_seen_d;
      state_chg_secs_q <= scs_cnt_d;
      byte_fail_secs_q <= abf_cnt_d;
    end
  end

  ptr_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    oh_valid && oh_sel == SEL_H1 && oh_sts < 4'hC |=> ptr_h1_q[$past(oh_sts)] == $past(oh_data))
    else $error("pointer byte not captured");

  concat_bad_a: assert property (@(posedge clk_sys) disable iff (reset)
    ptr_h2_q[11] != CONCAT_H2 |=> !concat_ok_q)
    else $error("concatenation accepted with bad pointer");

  state_change_a: assert property (@(posedge clk_sys) disable iff (reset)
    sec_tick && !test_start && (scs_seen_q || aps_chg)
      |=> state_chg_secs_q == $past(state_chg_secs_q) + 16'h0001)
    else $error("state change second not counted");

  fail_second_a: assert property (@(posedge clk_sys) disable iff (reset)
    sec_tick && !test_start && (abf_seen_q || abf_fail)
      |=> byte_fail_secs_q == $past(byte_fail_secs_q) + 16'h0001)
    else $error("byte failure second not counted");

  req_chan_a: assert property (@(posedge clk_sys) disable iff (reset)
    aps_upd && !test_start |=> req_chan_q == $past(toh_q[SEL_K1][3:0]))
    else $error("requested channel wrong");

  chan_class_a: assert property (@(posedge clk_sys) disable iff (reset)
    chan_working_q |-> req_chan_q != 4'h0 && req_chan_q != 4'hF && !chan_null_q)
    else $error("channel class inconsistent");

  bridge_arch_a: assert property (@(posedge clk_sys) disable iff (reset)
    aps_upd && !test_start |=> bridge_chan_q == $past(oh_data[7:4])
      && arch_one_to_n_q == $past(oh_data[3]))
    else $error("bridged channel or architecture wrong");

  mode_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
    remote_failure_indication_q |-> switch_mode_q == 3'h6 && !mode_reserved_q)
    else $error("switching mode decode wrong");

  unused_code_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_unused_q |-> protection_state_message_q inside {4'h3, 4'h5, 4'h7, 4'h9})
    else $error("unused state code flag wrong");

  counter_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    test_start |=> state_chg_secs_q == 16'h0000 && byte_fail_secs_q == 16'h0000)
    else $error("counters not cleared at test start");
endmodule

`default_nettype wire

// File: spm_line_model.sv
// far-end line model: offers transport overhead bytes, one per cycle
// assumes the bench calls its tasks from one process tied to clk_sys
`timescale 1ns/1ps
`default_nettype none

module spm_line_model (
  input  wire logic       clk_sys,
  output var  logic       oh_valid,
  output var  logic [3:0] oh_sts,
  output var  logic [4:0] oh_sel,
  output var  logic [7:0] oh_data
);
  import spm_pkg::*;

  initial begin
    oh_valid = 1'b0;
    oh_sts   = 4'h0;
    oh_sel   = 5'h1F;
    oh_data  = 8'h00;
  end

  task automatic put(input logic [3:0] s, input logic [4:0] b, input logic [7:0] d);
    @(posedge clk_sys);
    oh_valid <= 1'b1;
    oh_sts   <= s;
    oh_sel   <= b;
    oh_data  <= d;
  endtask

  // data toggles while idle so a stale byte never passes for a fresh one
  task automatic idle();
    @(posedge clk_sys);
    oh_valid <= 1'b0;
    oh_sel   <= 5'h1F;
    oh_data  <= ~oh_data;
  endtask

  task automatic frame(input logic [7:0] k1, input logic [7:0] k2);
    put(STS_FIRST, SEL_K1, k1);
    put(STS_FIRST, SEL_K2, k2);
  endtask
endmodule
`default_nettype wire

// File: spm_overhead_monitor_tb_top.sv
// self-checking bench for the overhead monitor
// assumes spm_pkg and the line model are compiled first
`timescale 1ns/1ps
`default_nettype none

module spm_overhead_monitor_tb_top;
  import spm_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, sec_tick = 1'b0, test_start = 1'b0;
  logic oh_valid;
  logic [3:0] oh_sts, req_chan_q, bridge_chan_q;
  logic [4:0] oh_sel;
  logic [7:0] oh_data;
  logic [11:0][7:0] ptr_h1_q, ptr_h2_q, h1, h2;
  logic [20:0][7:0] toh_q, t;
  logic concat_ok_q, chan_null_q, chan_extra_q, chan_working_q, state_unused_q;
  logic arch_one_to_n_q, mode_reserved_q, mode_unidir_q, mode_bidir_q;
  logic remote_failure_indication_q, line_ais_q, aps_fail_q, k2_seen = 1'b0;
  spm_state_e psm;
  logic [2:0] switch_mode_q;
  logic [15:0] state_chg_secs_q, byte_fail_secs_q;
  logic [31:0] seed = 32'h7C6F;
  logic [24:0] exp_q[$];
  int mismatches = 0, total_checks = 0, fail_cnt = 0;
  wire logic [24:0] dec_got = {req_chan_q, chan_null_q, chan_extra_q, chan_working_q,
    bridge_chan_q, psm, state_unused_q, arch_one_to_n_q, switch_mode_q, mode_reserved_q,
    mode_unidir_q, mode_bidir_q, remote_failure_indication_q, line_ais_q};

  always #12.5 clk_sys = ~clk_sys;

  spm_line_model i_spm_line_model (.clk_sys(clk_sys), .oh_valid(oh_valid),
    .oh_sts(oh_sts), .oh_sel(oh_sel), .oh_data(oh_data));

  spm_overhead_monitor i_spm_overhead_monitor (
    .clk_sys                    (clk_sys),
    .reset                      (reset),
    .oh_valid                   (oh_valid),
    .oh_sts                     (oh_sts),
    .oh_sel                     (oh_sel),
    .oh_data                    (oh_data),
    .sec_tick                   (sec_tick),
    .test_start                 (test_start),
    .ptr_h1_q                   (ptr_h1_q),
    .ptr_h2_q                   (ptr_h2_q),
    .concat_ok_q                (concat_ok_q),
    .toh_q                      (toh_q),
    .req_chan_q                 (req_chan_q),
    .chan_null_q                (chan_null_q),
    .chan_extra_q               (chan_extra_q),
    .chan_working_q             (chan_working_q),
    .bridge_chan_q              (bridge_chan_q),
    .protection_state_message_q (psm),
    .state_unused_q             (state_unused_q),
    .arch_one_to_n_q            (arch_one_to_n_q),
    .switch_mode_q              (switch_mode_q),
    .mode_reserved_q            (mode_reserved_q),
    .mode_unidir_q              (mode_unidir_q),
    .mode_bidir_q               (mode_bidir_q),
    .remote_failure_indication_q(remote_failure_indication_q),
    .line_ais_q                 (line_ais_q),
    .aps_fail_q                 (aps_fail_q),
    .state_chg_secs_q           (state_chg_secs_q),
    .byte_fail_secs_q           (byte_fail_secs_q)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // byte bit 7 is line bit 1, so k1 bits 1-4 sit in [7:4]
  function automatic logic [24:0] exp_dec(input logic [7:0] k1, input logic [7:0] k2);
    logic [3:0] c;
    logic [2:0] m;
    c = k1[3:0];
    m = k2[2:0];
    return {c, c == CHAN_NULL, c == CHAN_EXTRA, c != CHAN_NULL && c != CHAN_EXTRA,
      k2[7:4], k1[7:4], k1[7:4] inside {4'h3, 4'h5, 4'h7, 4'h9}, k2[3], m,
      m < MODE_UNI, m == MODE_UNI, m == MODE_BI, m == MODE_RFI, m == MODE_AIS};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic send(input logic [7:0] k1, input logic [7:0] k2);
    exp_q.push_back(exp_dec(k1, k2));
    i_spm_line_model.frame(k1, k2);
  endtask

  task automatic pulse(input bit start);
    @(posedge clk_sys);
    if (start) test_start <= 1'b1;
    else sec_tick <= 1'b1;
    @(posedge clk_sys);
    test_start <= 1'b0;
    sec_tick <= 1'b0;
    tick(2);
  endtask

  task automatic secs(input logic [15:0] c, input logic [15:0] f);
    chk("state_chg_secs", c, state_chg_secs_q);
    chk("byte_fail_secs", f, byte_fail_secs_q);
  endtask

  // decoded fields show one cycle after the K2 edge; oldest note first
  always @(posedge clk_sys) begin
    if (k2_seen) begin
      if (exp_q.size() == 0) chk("note", 32'h0, 32'h1);
      else chk("decode", exp_q.pop_front(), dec_got);
    end
    if (aps_fail_q === 1'b1) fail_cnt++;
    k2_seen = oh_valid && oh_sel == SEL_K2 && oh_sts == STS_FIRST;
  end

  initial begin
    tick(20000);
    mismatches++;
    give_verdict();
  end

  initial begin
    tick(5);
    @(posedge clk_sys);
    reset <= 1'b0;
    chk("null_at_reset", 1'b1, chan_null_q);
    chk("mode_at_reset", 1'b1, mode_reserved_q);
    secs(16'h0, 16'h0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      send({i[3:0], ~i[3:0]}, {seed[7:4], i[3:0]});
    end
    for (int s = 0; s < 12; s++) begin
      seed = lfsr(seed);
      h1[s] = (s == 0) ? seed[7:0] : CONCAT_H1;
      h2[s] = (s == 0) ? seed[15:8] : CONCAT_H2;
      i_spm_line_model.put(s[3:0], SEL_H1, h1[s]);
      i_spm_line_model.put(s[3:0], SEL_H2, h2[s]);
    end
    i_spm_line_model.idle();
    tick(2);
    for (int s = 0; s < 12; s++) begin
      chk("ptr_h1", h1[s], ptr_h1_q[s]);
      chk("ptr_h2", h2[s], ptr_h2_q[s]);
    end
    chk("concat_ok", 1'b1, concat_ok_q);
    i_spm_line_model.put(4'hB, SEL_H2, 8'hFE);
    i_spm_line_model.idle();
    tick(3);
    chk("concat_broken", 1'b0, concat_ok_q);
    // bytes from a later sts-1 must not overwrite the display copy
    for (int b = 0; b <= SEL_LAST; b++) begin
      seed = lfsr(seed);
      t[b] = seed[7:0];
      if (b == SEL_K2) exp_q.push_back(exp_dec(t[SEL_K1], t[b]));
      i_spm_line_model.put(STS_FIRST, b[4:0], t[b]);
      i_spm_line_model.put(4'h3, b[4:0], ~t[b]);
    end
    i_spm_line_model.idle();
    tick(2);
    for (int b = 0; b <= SEL_LAST; b++) chk("toh", t[b], toh_q[b]);
    pulse(1'b1);
    fail_cnt = 0;
    for (int f = 0; f < 8; f++) send({4'hC, f[3:0]}, 8'h15);
    for (int f = 0; f < 6; f++) send(8'hC7, 8'h15);
    i_spm_line_model.idle();
    tick(4);
    chk("fail_pulses", 32'h1, fail_cnt);
    pulse(1'b0);
    secs(16'h1, 16'h1);
    send(8'hC7, 8'h15);
    send(8'hC7, 8'h15);
    i_spm_line_model.idle();
    tick(4);
    pulse(1'b0);
    secs(16'h1, 16'h1);
    for (int f = 0; f < 7; f++) send({4'hD, f[3:0]}, 8'h26);
    i_spm_line_model.idle();
    tick(4);
    chk("fail_seven", 32'h1, fail_cnt);
    pulse(1'b0);
    secs(16'h2, 16'h1);
    pulse(1'b1);
    secs(16'h0, 16'h0);
    chk("notes_left", 32'h0, exp_q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
